// ---- src/ext_config_space_port.sv ----
// Purpose: Forwards configuration reads and writes from the link to user-held registers.
// Assumes: Link requests and user answers are all on clk; no synchroniser is needed.
// Notes: Only one read is tracked at a time; link_req_ready holds requests off meanwhile.
//
// Overview of operation
// - One-cycle read-seen pulse for every read.
// - Ten-bit register number valid during pulses.
// - Eight-bit function number valid during pulses.
// - Reads at 0xB0 to 0xBF are legacy.
// - Reads at 0x120 to 0x13F are extended.
// - In-window writes raise write-seen with fields.
// - Thirty-two-bit data, four-bit enables on writes.
// - Read data captured on the edge that samples read-valid high.
// - Read-valid sampled edge after read-seen.
// - No answer in 262144 cycles: zero completion.
// - Pulses only when extended space enabled.
`default_nettype none

module ext_config_space_port
#(
  parameter int unsigned TIMEOUT_CYCLES = ext_cfg_pkg::READ_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,

  // Core configuration option
  input wire logic ext_space_enable,

  // Configuration requests arriving from the link
  input wire logic link_req_valid,
  output logic link_req_ready,
  input wire logic link_req_write,
  input wire logic [ext_cfg_pkg::REG_NUM_W-1:0] link_req_reg_num,
  input wire logic [ext_cfg_pkg::FUNC_NUM_W-1:0] link_req_func_num,
  input wire logic [ext_cfg_pkg::DATA_W-1:0] link_req_wr_data,
  input wire logic [ext_cfg_pkg::BYTE_EN_W-1:0] link_req_byte_en,

  // Read answers returned toward the link
  output logic cpl_valid,
  output logic [ext_cfg_pkg::DATA_W-1:0] cpl_data,
  output logic cpl_external,
  output logic cpl_auto,
  output logic [ext_cfg_pkg::REG_NUM_W-1:0] cpl_reg_num,
  output logic [ext_cfg_pkg::FUNC_NUM_W-1:0] cpl_func_num,

  // Indications toward user logic
  output logic rd_seen,
  output logic wr_seen,
  output logic [ext_cfg_pkg::REG_NUM_W-1:0] reg_num,
  output logic [ext_cfg_pkg::FUNC_NUM_W-1:0] func_num,
  output logic [ext_cfg_pkg::DATA_W-1:0] wr_data,
  output logic [ext_cfg_pkg::BYTE_EN_W-1:0] wr_byte_en,

  // Read answer from user logic
  input wire logic [ext_cfg_pkg::DATA_W-1:0] user_rd_data,
  input wire logic user_rd_valid
);

  // Read tracking state.
  ext_cfg_pkg::rd_state_e state_q;
  ext_cfg_pkg::rd_state_e state_d;

  // Registered outputs.
  logic rd_seen_q;
  logic wr_seen_q;
  logic [ext_cfg_pkg::REG_NUM_W-1:0] reg_num_q;
  logic [ext_cfg_pkg::FUNC_NUM_W-1:0] func_num_q;
  logic [ext_cfg_pkg::DATA_W-1:0] wr_data_q;
  logic [ext_cfg_pkg::BYTE_EN_W-1:0] wr_byte_en_q;
  logic cpl_valid_q;
  logic [ext_cfg_pkg::DATA_W-1:0] cpl_data_q;
  logic cpl_external_q;
  logic cpl_auto_q;
  logic [ext_cfg_pkg::REG_NUM_W-1:0] cpl_reg_num_q;
  logic [ext_cfg_pkg::FUNC_NUM_W-1:0] cpl_func_num_q;

  // Request decode.
  logic req_take;
  logic req_in_legacy;
  logic req_in_extended;
  logic req_in_window;
  logic fwd_read;
  logic fwd_write;
  logic local_read;
  logic [ext_cfg_pkg::DATA_W-1:0] wr_data_masked;

  // Answer decode.
  logic waiting;
  logic user_answer;
  logic wait_expired;
  logic timer_last;

  // Window classification of the incoming register number.
  cfg_range_classify u_classify
  (
    .reg_num(link_req_reg_num),
    .in_legacy(req_in_legacy),
    .in_extended(req_in_extended),
    .in_any(req_in_window)
  );

  // Single read outstanding.
  // Requests are only taken while no read waits, so the shared fields never change mid-read.
  assign link_req_ready = (state_q == ext_cfg_pkg::S_IDLE);
  assign req_take = link_req_valid && link_req_ready;

  // Forwarding needs the option.
  // With the option off the user side stays silent and reads are answered locally at once.
  assign fwd_read = req_take && !link_req_write && ext_space_enable;
  assign fwd_write = req_take && link_req_write && ext_space_enable && req_in_window;

  // Only windowed reads wait.
  // A forwarded read outside both windows is still shown to user logic but never awaited.
  assign local_read = req_take && !link_req_write && !(ext_space_enable && req_in_window);

  // Per-lane byte qualification.
  // Disabled lanes read as zero so user logic cannot latch stale bytes by mistake.
  for (genvar lane = 0; lane < ext_cfg_pkg::BYTE_EN_W; lane++)
  begin : g_lane
    assign wr_data_masked[lane*ext_cfg_pkg::BYTE_W +: ext_cfg_pkg::BYTE_W] =
      link_req_byte_en[lane] ? link_req_wr_data[lane*ext_cfg_pkg::BYTE_W +: ext_cfg_pkg::BYTE_W]
                             : '0;
  end

  // Wait-state qualifiers.
  assign waiting = (state_q == ext_cfg_pkg::S_WAIT);

  // Strobe sampled while waiting.
  // The first sample is the edge that ends the read-seen pulse, since the wait starts with it.
  assign user_answer = waiting && user_rd_valid;

  // Time-out without answer.
  // A strobe in the very last allowed cycle still wins over the automatic answer.
  assign wait_expired = timer_last && !user_rd_valid;

  // Counts the cycles of the current wait.
  read_timeout_timer #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .run(waiting),
    .last_cycle(timer_last)
  );

  // Next read state.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ext_cfg_pkg::S_IDLE:
      begin
        if (fwd_read && req_in_window)
        begin
          state_d = ext_cfg_pkg::S_WAIT;
        end
      end
      ext_cfg_pkg::S_WAIT:
      begin
        if (user_answer || wait_expired)
        begin
          state_d = ext_cfg_pkg::S_IDLE;
        end
      end
    endcase
  end

  // Late data is ignored.
  // Once back in idle the read strobe is no longer looked at, so a late answer has no effect.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ext_cfg_pkg::S_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // One-cycle read pulse.
  // Every forwarded read pulses, whatever its address; the request is taken only once.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_seen_q <= 1'b0;
    end
    else
    begin
      rd_seen_q <= fwd_read;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_seen_q <= 1'b0;
    end
    else
    begin
      wr_seen_q <= fwd_write;
    end
  end

  // Register and function number capture.
  // The fields hold after the pulse so user logic may look at them a cycle late.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_num_q <= ext_cfg_pkg::REG_NUM_RESET;
      func_num_q <= ext_cfg_pkg::FUNC_NUM_RESET;
    end
    else if (fwd_read || fwd_write)
    begin
      reg_num_q <= link_req_reg_num;
      func_num_q <= link_req_func_num;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_data_q <= ext_cfg_pkg::DATA_RESET;
      wr_byte_en_q <= ext_cfg_pkg::BYTE_EN_RESET;
    end
    else if (fwd_write)
    begin
      wr_data_q <= wr_data_masked;
      wr_byte_en_q <= link_req_byte_en;
    end
  end

  // Completion pulse: user answer, time-out, or a read the core answers itself.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpl_valid_q <= 1'b0;
      cpl_external_q <= 1'b0;
      cpl_auto_q <= 1'b0;
    end
    else
    begin
      cpl_valid_q <= user_answer || wait_expired || local_read;
      cpl_external_q <= user_answer || wait_expired;
      cpl_auto_q <= wait_expired;
    end
  end

  // Zero payload on time-out.
  // Local reads carry zero here; the core supplies its own register contents for them.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpl_data_q <= ext_cfg_pkg::DATA_RESET;
    end
    else if (user_answer)
    begin
      cpl_data_q <= user_rd_data;
    end
    else if (wait_expired || local_read)
    begin
      cpl_data_q <= ext_cfg_pkg::AUTO_PAYLOAD;
    end
  end

  // Completion addressing follows the read it answers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpl_reg_num_q <= ext_cfg_pkg::REG_NUM_RESET;
      cpl_func_num_q <= ext_cfg_pkg::FUNC_NUM_RESET;
    end
    else if (local_read)
    begin
      cpl_reg_num_q <= link_req_reg_num;
      cpl_func_num_q <= link_req_func_num;
    end
    else if (user_answer || wait_expired)
    begin
      cpl_reg_num_q <= reg_num_q;
      cpl_func_num_q <= func_num_q;
    end
  end

  // Output drive, all from flip-flops except the ready handshake.
  assign rd_seen = rd_seen_q;
  assign wr_seen = wr_seen_q;
  assign reg_num = reg_num_q;
  assign func_num = func_num_q;
  assign wr_data = wr_data_q;
  assign wr_byte_en = wr_byte_en_q;
  assign cpl_valid = cpl_valid_q;
  assign cpl_data = cpl_data_q;
  assign cpl_external = cpl_external_q;
  assign cpl_auto = cpl_auto_q;
  assign cpl_reg_num = cpl_reg_num_q;
  assign cpl_func_num = cpl_func_num_q;

endmodule // ext_config_space_port

`default_nettype wire

// ---- src/ext_cfg_pkg.sv ----
// Purpose: Shared constants and types for the external configuration space port.
// Assumes: One user clock at 125 MHz; all request and answer signals are on that clock.
// Notes: The read time-out figure is a cycle count of the user clock.
`default_nettype none

package ext_cfg_pkg;

  // Field widths of the forwarded request.
  localparam int unsigned REG_NUM_W = 10;
  localparam int unsigned FUNC_NUM_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_EN_W = 4;
  localparam int unsigned BYTE_W = 8;

  // Register-number windows that user logic serves.
  localparam logic [REG_NUM_W-1:0] LEGACY_LO = 10'h0B0;
  localparam logic [REG_NUM_W-1:0] LEGACY_HI = 10'h0BF;
  localparam logic [REG_NUM_W-1:0] EXTENDED_LO = 10'h120;
  localparam logic [REG_NUM_W-1:0] EXTENDED_HI = 10'h13F;

  // Read answer time-out, in user clock cycles, and the counter width that holds it.
  localparam int unsigned READ_TIMEOUT_CYCLES = 262144;
  localparam int unsigned TIMER_W = 19;

  // Payload of the automatic answer after a time-out.
  localparam logic [DATA_W-1:0] AUTO_PAYLOAD = 32'h0000_0000;

  // Reset values of the captured request fields.
  localparam logic [REG_NUM_W-1:0] REG_NUM_RESET = 10'h000;
  localparam logic [FUNC_NUM_W-1:0] FUNC_NUM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [BYTE_EN_W-1:0] BYTE_EN_RESET = 4'h0;

  // Read tracking state.
  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } rd_state_e;

endpackage : ext_cfg_pkg

`default_nettype wire

// ---- src/cfg_range_classify.sv ----
// Purpose: Sorts a register number into the legacy or extended window served by user logic.
// Assumes: Purely combinational; the caller registers whatever it needs.
// Notes: The two windows do not overlap, so in_legacy and in_extended are never high together.
`default_nettype none

module cfg_range_classify
(
  // Register number under test
  input wire logic [ext_cfg_pkg::REG_NUM_W-1:0] reg_num,
  // Window flags
  output logic in_legacy,
  output logic in_extended,
  output logic in_any
);

  assign in_legacy = (reg_num >= ext_cfg_pkg::LEGACY_LO) && (reg_num <= ext_cfg_pkg::LEGACY_HI);

  assign in_extended = (reg_num >= ext_cfg_pkg::EXTENDED_LO) && (reg_num <= ext_cfg_pkg::EXTENDED_HI);

  // Either window means user logic owns the register.
  assign in_any = in_legacy || in_extended;

endmodule // cfg_range_classify

`default_nettype wire

// ---- src/read_timeout_timer.sv ----
// Purpose: Counts the cycles a forwarded read has waited and flags the last allowed one.
// Assumes: run stays high for the whole wait and drops as soon as the read is answered.
// Notes: The limit is a parameter so that a simulation can shorten it.
`default_nettype none

module read_timeout_timer
#(
  parameter int unsigned TIMEOUT_CYCLES = ext_cfg_pkg::READ_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  // Status
  output logic last_cycle
);

  localparam logic [ext_cfg_pkg::TIMER_W-1:0] LIMIT = ext_cfg_pkg::TIMER_W'(TIMEOUT_CYCLES - 1);

  logic [ext_cfg_pkg::TIMER_W-1:0] count_q;

  // The count restarts from zero whenever no read is waiting, so each read gets a full budget.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else if (!run)
    begin
      count_q <= '0;
    end
    else if (count_q != LIMIT)
    begin
      count_q <= count_q + 1'b1;
    end
  end

  assign last_cycle = run && (count_q == LIMIT);

endmodule // read_timeout_timer

`default_nettype wire

// ---- sim/ext_cfg_port_chk_asserts.sv ----
// Purpose: Concurrent checks on the pins of the configuration port.
// Assumes: One clock; rst_n low is an asynchronous reset.
// Notes: wait_q counts the cycles in which requests are held off.
`default_nettype none

module ext_cfg_port_chk
#(
  parameter int unsigned TIMEOUT_CYCLES = 12
)
(
  // Clock, reset and option
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_space_enable,
  // Link request
  input wire logic link_req_valid,
  input wire logic link_req_ready,
  input wire logic link_req_write,
  input wire logic [9:0] link_req_reg_num,
  input wire logic [7:0] link_req_func_num,
  input wire logic [31:0] link_req_wr_data,
  input wire logic [3:0] link_req_byte_en,
  // Answer toward the link
  input wire logic cpl_valid,
  input wire logic [31:0] cpl_data,
  input wire logic cpl_external,
  input wire logic cpl_auto,
  // User side
  input wire logic rd_seen,
  input wire logic wr_seen,
  input wire logic [9:0] reg_num,
  input wire logic [7:0] func_num,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_byte_en,
  input wire logic [31:0] user_rd_data,
  input wire logic user_rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take_rd;
  logic [31:0] mask;
  int unsigned wait_q;

  function automatic logic win(input logic [9:0] r);
    return (r >= 10'h0B0 && r <= 10'h0BF) || (r >= 10'h120 && r <= 10'h13F);
  endfunction

  // Read take and the lane mask that the byte enables imply.
  assign take_rd = link_req_valid && link_req_ready && !link_req_write;
  assign mask = {{8{link_req_byte_en[3]}}, {8{link_req_byte_en[2]}},
    {8{link_req_byte_en[1]}}, {8{link_req_byte_en[0]}}};

  // Held-off cycles; a counter, because the limit is far too long to unroll.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wait_q <= 0;
    else if (link_req_ready)
      wait_q <= 0;
    else
      wait_q <= wait_q + 1;

  sequence win_rd_s;
    rd_seen && win(reg_num);
  endsequence
  sequence user_ans_s;
    win_rd_s ##0 user_rd_valid;
  endsequence
  // Ready is low exactly while a windowed read waits, so this is any answer, early or late.
  sequence wait_ans_s;
    !link_req_ready && user_rd_valid;
  endsequence

  rd_pulse_a: assert property (rd_seen == $past(take_rd && ext_space_enable))
    else $error("read-seen does not follow the read take");
  rd_fields_a: assert property (
    rd_seen |-> reg_num == $past(link_req_reg_num) && func_num == $past(link_req_func_num))
    else $error("read fields wrong");
  wr_fwd_a: assert property (
    wr_seen == $past(link_req_valid && link_req_ready && link_req_write &&
      ext_space_enable && win(link_req_reg_num)))
    else $error("write-seen does not follow an in-window write");
  wr_lanes_a: assert property (
    wr_seen |-> wr_data == $past(link_req_wr_data & mask) && wr_byte_en == $past(link_req_byte_en))
    else $error("write data or lanes wrong");
  hold_off_a: assert property (win_rd_s |-> !link_req_ready)
    else $error("second read accepted while one waits");
  user_cpl_a: assert property (
    user_ans_s |=> cpl_valid && cpl_external && !cpl_auto && cpl_data == $past(user_rd_data))
    else $error("user answer not captured");
  wait_ans_a: assert property (
    wait_ans_s |=> cpl_valid && cpl_external && !cpl_auto && cpl_data == $past(user_rd_data))
    else $error("delayed user answer not captured");
  local_cpl_a: assert property (
    take_rd && !(ext_space_enable && win(link_req_reg_num)) |=> cpl_valid && !cpl_external)
    else $error("local read not answered at once");
  auto_cpl_a: assert property (
    cpl_auto |-> cpl_valid && wait_q == TIMEOUT_CYCLES && cpl_data == 32'h0000_0000)
    else $error("automatic answer at wrong time or data");
  wait_bound_a: assert property (wait_q <= TIMEOUT_CYCLES)
    else $error("read waited past the limit");
endmodule // ext_cfg_port_chk

bind ext_config_space_port ext_cfg_port_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) ext_cfg_port_chk_i (
  .clk(clk), .rst_n(rst_n), .ext_space_enable(ext_space_enable),
  .link_req_valid(link_req_valid), .link_req_ready(link_req_ready), .link_req_write(link_req_write),
  .link_req_reg_num(link_req_reg_num), .link_req_func_num(link_req_func_num),
  .link_req_wr_data(link_req_wr_data), .link_req_byte_en(link_req_byte_en),
  .cpl_valid(cpl_valid), .cpl_data(cpl_data), .cpl_external(cpl_external), .cpl_auto(cpl_auto),
  .rd_seen(rd_seen), .wr_seen(wr_seen), .reg_num(reg_num), .func_num(func_num),
  .wr_data(wr_data), .wr_byte_en(wr_byte_en), .user_rd_data(user_rd_data), .user_rd_valid(user_rd_valid));

`default_nettype wire

// ---- sim/ext_cfg_user_model.sv ----
// Purpose: User logic that holds the windowed configuration registers.
// Assumes: Answers come delay cycles after read-seen; delay 0 answers in that cycle.
// Notes: Idle read data toggles so that stale values cannot pass.
`default_nettype none

module ext_cfg_user_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Forwarded read
  input wire logic rd_seen,
  input wire logic [9:0] reg_num,
  input wire logic [7:0] func_num,
  // Test control
  input wire logic silent,
  input wire logic [3:0] delay,
  // Answer
  output logic [31:0] user_rd_data,
  output logic user_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit;
  logic pend_q;
  logic [3:0] w_q;
  logic [31:0] noise_q;

  // Windowed reads only; a silent model never answers late.
  assign hit = rd_seen && !silent &&
    ((reg_num >= 10'h0B0 && reg_num <= 10'h0BF) || (reg_num >= 10'h120 && reg_num <= 10'h13F));
  assign user_rd_valid = (hit && delay == 4'h0) || (pend_q && w_q == 4'h0);
  assign user_rd_data = user_rd_valid ? {8'hC3, func_num, 6'h15, reg_num} : noise_q;

  // Countdown of a slow answer, and the idle pattern.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pend_q <= 1'b0;
      w_q <= 4'h0;
      noise_q <= 32'hA5A5_5A5A;
    end
    else
    begin
      noise_q <= ~noise_q;
      if (hit && delay != 4'h0)
      begin
        pend_q <= 1'b1;
        w_q <= delay - 4'h1;
      end
      else if (pend_q && w_q == 4'h0)
        pend_q <= 1'b0;
      else if (pend_q)
        w_q <= w_q - 4'h1;
    end
endmodule // ext_cfg_user_model

`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the configuration port with its user model.
// Assumes: Time-out shortened to TO cycles.
// Notes: Answers are logged by a monitor and compared in order.
`default_nettype none
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic silent = 1'b0;
  logic [3:0] delay = 4'h0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [9:0] req_reg = 10'h000;
  logic [7:0] req_func = 8'h00;
  logic [31:0] req_data = 32'h0;
  logic [3:0] req_be = 4'h0;
  logic ready, cpl_valid, cpl_external, cpl_auto, rd_seen, wr_seen, u_valid;
  logic [9:0] cpl_reg_num, reg_num;
  logic [7:0] cpl_func_num, func_num;
  logic [31:0] cpl_data, wr_data, u_data;
  logic [3:0] wr_byte_en;
  // Completion log entry: function, register, auto flag, external flag, data.
  logic [51:0] cq[$];
  logic [35:0] wq[$];
  int cyc = 0;
  int last_cpl = 0;
  int n_rd = 0;
  int n_errors = 0;
  int n_compared = 0;

  ext_config_space_port #(.TIMEOUT_CYCLES(TO)) ext_config_space_port_i (.clk(clk), .rst_n(rst_n),
    .ext_space_enable(en), .link_req_valid(req_valid), .link_req_ready(ready), .link_req_write(req_write),
    .link_req_reg_num(req_reg), .link_req_func_num(req_func), .link_req_wr_data(req_data), .link_req_byte_en(req_be),
    .cpl_valid(cpl_valid), .cpl_data(cpl_data), .cpl_external(cpl_external), .cpl_auto(cpl_auto),
    .cpl_reg_num(cpl_reg_num), .cpl_func_num(cpl_func_num), .rd_seen(rd_seen), .wr_seen(wr_seen), .reg_num(reg_num),
    .func_num(func_num), .wr_data(wr_data), .wr_byte_en(wr_byte_en), .user_rd_data(u_data), .user_rd_valid(u_valid));
  ext_cfg_user_model ext_cfg_user_model_i (.clk(clk), .rst_n(rst_n), .rd_seen(rd_seen), .reg_num(reg_num),
    .func_num(func_num), .silent(silent), .delay(delay), .user_rd_data(u_data), .user_rd_valid(u_valid));

  always #4 clk = ~clk;

  // Monitor; values read here are those of the cycle that just ended.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cpl_valid === 1'b1)
    begin
      cq.push_back({cpl_func_num, cpl_reg_num, cpl_auto, cpl_external, cpl_data});
      last_cpl = cyc;
    end
    if (wr_seen === 1'b1)
      wq.push_back({wr_byte_en, wr_data});
    if (rd_seen === 1'b1)
      n_rd <= n_rd + 1;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Holds the request until an edge that sees ready; leaves valid up for back-to-back use.
  task automatic send(input logic w, input logic [9:0] r, input logic [7:0] f,
    input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_reg <= r;
    req_func <= f;
    req_data <= d;
    req_be <= b;
    @(posedge clk);
    while (ready !== 1'b1 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic idle();
    req_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_cpl(input logic [51:0] e);
    int k;
    logic [51:0] v;
    k = 0;
    @(negedge clk);
    while (cq.size() == 0 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    v = (cq.size() > 0) ? cq.pop_front() : 52'h0;
    `CHK(v, e)
    @(posedge clk);
  endtask

  task automatic t_local();
    logic [9:0] regs [4] = '{10'h0AF, 10'h0C0, 10'h11F, 10'h140};
    for (int i = 0; i < 4; i++)
      send(1'b0, regs[i], 8'h05, 32'h0, 4'h0);
    send(1'b1, 10'h0C0, 8'h05, 32'hFFFF_FFFF, 4'hF);
    idle();
    for (int i = 0; i < 4; i++)
      chk_cpl({8'h05, regs[i], 2'b00, 32'h0});
    `CHK(wq.size(), 0)
  endtask

  task automatic t_window();
    logic [9:0] regs [4] = '{10'h0B0, 10'h0BF, 10'h120, 10'h13F};
    for (int i = 0; i < 4; i++)
    begin
      delay <= 4'(i);
      send(1'b0, regs[i], 8'h40 + 8'(i), 32'h0, 4'h0);
      idle();
      chk_cpl({8'h40 + 8'(i), regs[i], 2'b01, 8'hC3, 8'h40 + 8'(i), 6'h15, regs[i]});
    end
  endtask

  task automatic t_timeout();
    int t0;
    silent <= 1'b1;
    send(1'b0, 10'h0B8, 8'h21, 32'h0, 4'h0);
    t0 = cyc;
    send(1'b1, 10'h121, 8'h22, 32'h1234_5678, 4'h9);
    `CHK(cyc - t0, TO + 1)
    idle();
    chk_cpl({8'h21, 10'h0B8, 2'b11, 32'h0});
    `CHK(last_cpl - t0, TO + 1)
    `CHK(wq.size(), 1)
    `CHK(wq[0], {4'h9, 32'h1200_0078})
    wq.delete();
    silent <= 1'b0;
  endtask

  task automatic t_disabled();
    en <= 1'b0;
    send(1'b0, 10'h0B0, 8'h01, 32'h0, 4'h0);
    send(1'b1, 10'h120, 8'h01, 32'hFFFF_FFFF, 4'hF);
    idle();
    chk_cpl({8'h01, 10'h0B0, 2'b00, 32'h0});
    `CHK(wq.size(), 0)
    en <= 1'b1;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_local();
    $display("test local reads done");
    t_window();
    $display("test windowed reads done");
    t_timeout();
    $display("test time-out done");
    t_disabled();
    $display("test disabled option done");
    `CHK(n_rd, 9)
    stop_test();
  end

  // Whole run needs under a hundred cycles.
  initial
  begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule // tb

`default_nettype wire
